// ==== rcf_pkg.sv ====
// Shared constants and carrier types of the remote command framer
package rcf_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned RATE_HI_BPS = 115200;
  localparam int unsigned RATE_MID_BPS = 38400;
  localparam int unsigned RATE_LO_BPS = 9600;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(CLK_HZ / RATE_HI_BPS);
  localparam logic [DIV_W-1:0] DIV_MID = DIV_W'(CLK_HZ / RATE_MID_BPS);
  localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(CLK_HZ / RATE_LO_BPS);
  localparam int DATA_BITS = 8;
  localparam logic [3:0] TX_FRAME_BITS = 4'h9;
  localparam logic [2:0] RX_LAST_BIT = 3'h7;
  localparam logic [6:0] CH_OPEN = 7'h23;
  localparam logic [6:0] CH_CLOSE = 7'h2A;
  localparam logic [6:0] CH_QUERY = 7'h3F;
  localparam logic [6:0] CH_CR = 7'h0D;
  localparam logic [6:0] CH_LF = 7'h0A;

  typedef enum logic [1:0] {
    RCF_RATE_HI = 2'h0,
    RCF_RATE_MID = 2'h1,
    RCF_RATE_LO = 2'h2
  } rcf_rate_type;

  typedef enum logic {
    RCF_PORT_SER = 1'h0,
    RCF_PORT_USB = 1'h1
  } rcf_port_type;

  // One received command character event
  typedef struct packed {
    logic valid;
    logic start;
    logic stop;
    logic query;
    logic [6:0] chr;
  } rcf_cmd_type;

  // One byte on a link stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rcf_byte_type;
endpackage : rcf_pkg

// ==== rcf_uart.sv ====
// Serial character engine: 8N1 receiver and transmitter sharing one rate
`timescale 1ns/10ps
module rcf_uart
  import rcf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [DIV_W-1:0] div,
  input wire logic rxd,
  output logic txd,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_hold,
  output logic tx_ready,
  output logic tx_busy,
  output rcf_byte_type rx_out,
  output logic rx_ferr,
  output logic rx_busy
);
  typedef enum logic [1:0] {
    RCF_RX_IDLE = 2'h0,
    RCF_RX_START = 2'h1,
    RCF_RX_DATA = 2'h2,
    RCF_RX_STOP = 2'h3
  } rcf_rx_type;

  rcf_rx_type rx_st_r;
  logic [DIV_W-1:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic [DIV_W-1:0] tx_cnt_r;
  logic [3:0] tx_left_r;
  logic [8:0] tx_sh_r;

  assign rx_busy = (rx_st_r != RCF_RX_IDLE);
  // Half duplex: no start while a character is arriving
  assign tx_ready = !tx_busy && !tx_hold;

  // Receiver samples mid-bit, half a bit after the falling edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_st_r <= RCF_RX_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_out <= '0;
      rx_ferr <= 1'b0;
    end else begin
      rx_out.valid <= 1'b0;
      rx_ferr <= 1'b0;
      if (rx_st_r == RCF_RX_IDLE) begin
        if (!rxd) begin
          rx_st_r <= RCF_RX_START;
          rx_cnt_r <= div >> 1;
        end
      end else if (rx_cnt_r != '0) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= div - 1'b1;
        case (rx_st_r)
          RCF_RX_START: begin
            // A short low glitch is not a start bit
            rx_st_r <= rxd ? RCF_RX_IDLE : RCF_RX_DATA;
            rx_bit_r <= '0;
          end
          RCF_RX_DATA: begin
            rx_sh_r <= {rxd, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 1'b1;
            if (rx_bit_r == RX_LAST_BIT) begin
              rx_st_r <= RCF_RX_STOP;
            end
          end
          RCF_RX_STOP: begin
            rx_st_r <= RCF_RX_IDLE;
            rx_out.valid <= rxd;
            rx_out.data <= rx_sh_r;
            rx_ferr <= !rxd;
          end
          default: rx_st_r <= RCF_RX_IDLE;
        endcase
      end
    end
  end

  // Transmitter: start bit, eight data bits LSB first, one stop bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_busy <= 1'b0;
      txd <= 1'b1;
      tx_cnt_r <= '0;
      tx_left_r <= '0;
      tx_sh_r <= '0;
    end else if (!tx_busy) begin
      if (tx_valid && tx_ready) begin
        tx_busy <= 1'b1;
        txd <= 1'b0;
        tx_sh_r <= {1'b1, tx_data};
        tx_left_r <= TX_FRAME_BITS;
        tx_cnt_r <= div - 1'b1;
      end
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end else if (tx_left_r == '0) begin
      tx_busy <= 1'b0;
    end else begin
      txd <= tx_sh_r[0];
      tx_sh_r <= tx_sh_r >> 1;
      tx_left_r <= tx_left_r - 1'b1;
      tx_cnt_r <= div - 1'b1;
    end
  end

  chk_tx_start_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(tx_busy) |-> !txd && !$past(tx_hold))
    else $error("transmit started while held");
  chk_tx_idle_high: assert property (@(posedge sys_clk) disable iff (rst)
    !tx_busy |-> txd)
    else $error("line not idle high");
  chk_rx_stop_err: assert property (@(posedge sys_clk) disable iff (rst)
    rx_ferr |-> !rx_out.valid && $past(rx_st_r == RCF_RX_STOP) && !$past(rxd))
    else $error("framing error without low stop bit");
endmodule : rcf_uart

// ==== rcf_top.sv ====
// Remote command framer: port detection, command delimiting, reply framing
`timescale 1ns/10ps
module rcf_top
  import rcf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] rate_sel,
  input wire logic flow_en,
  input wire logic ser_rxd,
  output logic ser_txd,
  input wire logic ser_cts_n,
  output logic ser_rts_n,
  input wire rcf_byte_type usb_rx,
  output rcf_byte_type usb_tx,
  input wire logic usb_tx_ready,
  output rcf_cmd_type cmd_out,
  output logic cmd_ferr,
  output rcf_port_type port_sel,
  input wire logic rep_valid,
  input wire logic [7:0] rep_data,
  input wire logic rep_last,
  output logic rep_ready
);
  typedef enum logic [1:0] {
    RCF_CMD_OUT = 2'h0,
    RCF_CMD_FIRST = 2'h1,
    RCF_CMD_BODY = 2'h2
  } rcf_asm_type;

  typedef enum logic [1:0] {
    RCF_REP_DATA = 2'h0,
    RCF_REP_CR = 2'h1,
    RCF_REP_LF = 2'h2
  } rcf_rep_type;

  logic [DIV_W-1:0] div_nxt;
  rcf_byte_type ser_rx;
  logic ser_ferr;
  logic ser_rx_busy;
  logic ser_tx_busy;
  logic ser_tx_ready;
  logic ser_tx_valid;
  logic [7:0] tx_byte;
  logic tx_hold;
  logic in_valid;
  logic [6:0] in_chr;
  rcf_port_type in_port;
  rcf_asm_type asm_r;
  rcf_rep_type rep_st_r;
  logic query_pend_r;
  logic port_ready;
  logic out_valid;
  logic out_take;

  always_comb begin
    case (rate_sel)
      RCF_RATE_MID: div_nxt = DIV_MID;
      RCF_RATE_LO: div_nxt = DIV_LO;
      default: div_nxt = DIV_HI;
    endcase
  end

  // Clear-to-send only matters when handshaking is enabled
  assign tx_hold = ser_rx_busy || (flow_en && ser_cts_n);

  rcf_uart u_uart (
    .sys_clk(sys_clk),
    .rst(rst),
    .div(div_nxt),
    .rxd(ser_rxd),
    .txd(ser_txd),
    .tx_valid(ser_tx_valid),
    .tx_data(tx_byte),
    .tx_hold(tx_hold),
    .tx_ready(ser_tx_ready),
    .tx_busy(ser_tx_busy),
    .rx_out(ser_rx),
    .rx_ferr(ser_ferr),
    .rx_busy(ser_rx_busy)
  );

  // Readiness shown to the host: low while able to take characters
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ser_rts_n <= 1'b1;
    end else begin
      ser_rts_n <= flow_en && ser_tx_busy;
    end
  end

  // Serial wins a same-cycle tie; both ports carry one protocol
  always_comb begin
    in_port = ser_rx.valid ? RCF_PORT_SER : RCF_PORT_USB;
    in_chr = ser_rx.valid ? ser_rx.data[6:0] : usb_rx.data[6:0];
    in_valid = ser_rx.valid || usb_rx.valid;
  end

  // A port that opens a command becomes the active port unless a reply is pending
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_sel <= RCF_PORT_SER;
    end else if (in_valid && in_chr == CH_OPEN && rep_st_r == RCF_REP_DATA && !query_pend_r) begin
      port_sel <= in_port;
    end
  end

  // Command assembly; characters from the idle port other than an opener are dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      asm_r <= RCF_CMD_OUT;
      cmd_out <= '0;
      cmd_ferr <= 1'b0;
    end else begin
      cmd_out.valid <= 1'b0;
      cmd_out.start <= 1'b0;
      cmd_out.stop <= 1'b0;
      cmd_ferr <= 1'b0;
      if (ser_ferr && port_sel == RCF_PORT_SER) begin
        cmd_ferr <= 1'b1;
        asm_r <= RCF_CMD_OUT;
      end else if (in_valid && (in_chr == CH_OPEN)) begin
        asm_r <= RCF_CMD_FIRST;
        cmd_out.start <= 1'b1;
        cmd_out.query <= 1'b0;
        cmd_out.chr <= in_chr;
      end else if (in_valid && in_port == port_sel && asm_r != RCF_CMD_OUT) begin
        cmd_out.chr <= in_chr;
        if (in_chr == CH_CLOSE) begin
          asm_r <= RCF_CMD_OUT;
          cmd_out.stop <= 1'b1;
        end else begin
          asm_r <= RCF_CMD_BODY;
          cmd_out.valid <= 1'b1;
          if (asm_r == RCF_CMD_FIRST) begin
            cmd_out.query <= (in_chr == CH_QUERY);
          end
        end
      end
    end
  end

  // A finished query arms exactly one reply
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      query_pend_r <= 1'b0;
    end else if (cmd_out.stop && cmd_out.query) begin
      query_pend_r <= 1'b1;
    end else if (rep_st_r == RCF_REP_LF && out_take) begin
      query_pend_r <= 1'b0;
    end
  end

  assign port_ready = (port_sel == RCF_PORT_SER) ? ser_tx_ready : usb_tx_ready;
  assign out_valid = query_pend_r;
  assign out_take = out_valid && port_ready && (rep_st_r != RCF_REP_DATA || rep_valid);
  // Unsolicited reply bytes are swallowed so the core cannot stall
  assign rep_ready = (rep_st_r == RCF_REP_DATA) && (!query_pend_r || port_ready);

  always_comb begin
    case (rep_st_r)
      RCF_REP_CR: tx_byte = {1'b0, CH_CR};
      RCF_REP_LF: tx_byte = {1'b0, CH_LF};
      default: tx_byte = {1'b0, rep_data[6:0]};
    endcase
  end

  assign ser_tx_valid = out_take && (port_sel == RCF_PORT_SER);

  // Reply framing; the reply length is whatever the core supplies
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rep_st_r <= RCF_REP_DATA;
    end else if (out_take) begin
      case (rep_st_r)
        RCF_REP_DATA: rep_st_r <= rep_last ? RCF_REP_CR : RCF_REP_DATA;
        RCF_REP_CR: rep_st_r <= RCF_REP_LF;
        RCF_REP_LF: rep_st_r <= RCF_REP_DATA;
        default: rep_st_r <= RCF_REP_DATA;
      endcase
    end
  end

  // USB byte register keeps the data output off combinational paths
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      usb_tx <= '0;
    end else begin
      usb_tx.valid <= out_take && (port_sel == RCF_PORT_USB);
      usb_tx.data <= tx_byte;
    end
  end

  chk_no_unsolicited: assert property (@(posedge sys_clk) disable iff (rst)
    (ser_tx_valid || usb_tx.valid) |-> (query_pend_r || $past(query_pend_r)))
    else $error("reply without a pending query");
  chk_msb_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (ser_tx_valid |-> !tx_byte[7]) and (usb_tx.valid |-> !usb_tx.data[7]))
    else $error("transmitted top bit not zero");
  chk_cr_then_lf: assert property (@(posedge sys_clk) disable iff (rst)
    (out_take && rep_st_r == RCF_REP_CR) |=> rep_st_r == RCF_REP_LF && tx_byte == {1'b0, CH_LF})
    else $error("carriage return not followed by line feed");
  chk_query_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (in_valid && in_port == port_sel && asm_r == RCF_CMD_FIRST && !ser_ferr && in_chr == CH_QUERY)
      |=> cmd_out.query && cmd_out.valid)
    else $error("query not recognised");
  chk_open_restart: assert property (@(posedge sys_clk) disable iff (rst)
    (in_valid && in_chr == CH_OPEN && !(ser_ferr && port_sel == RCF_PORT_SER))
      |=> cmd_out.start && asm_r == RCF_CMD_FIRST && !cmd_out.query)
    else $error("opener did not restart assembly");
  chk_ferr_drop: assert property (@(posedge sys_clk) disable iff (rst)
    (ser_ferr && port_sel == RCF_PORT_SER) |=> cmd_ferr && asm_r == RCF_CMD_OUT)
    else $error("framing error did not drop command");
  chk_rate_default: assert property (@(posedge sys_clk) disable iff (rst)
    (rate_sel == 2'h3 || rate_sel == RCF_RATE_HI) |-> div_nxt == DIV_HI)
    else $error("default rate not selected");
endmodule : rcf_top

// ==== rcf_host_model.sv ====
// Host serial model: sends 8N1 characters and collects device replies
`timescale 1ns/10ps
module rcf_host_model
  import rcf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [DIV_W-1:0] div,
  output logic ser_rxd,
  input wire logic ser_txd,
  input wire logic ser_rts_n
);
  logic [8:0] rx_q[$];
  logic [8:0] shift;
  logic rx_busy;
  initial begin
    ser_rxd = 1'b1;
    rx_busy = 1'b0;
  end
  // Counted in clocks so bit edges stay clear of the sampling edge
  task automatic bit_time(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : bit_time
  // Low stop bit only when a framing fault is wanted
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    wait (!rx_busy);
    bit_time(1);
    for (int i = 0; i < 10; i++) begin
      ser_rxd = fr[i];
      bit_time(int'(div));
    end
    ser_rxd = 1'b1;
  endtask : send_byte
  // Mid-bit sampling; ready level kept with each byte in bit 8
  always begin
    @(negedge ser_txd);
    rx_busy = 1'b1;
    bit_time(int'(div) / 2);
    shift[8] = ser_rts_n;
    for (int i = 0; i < 8; i++) begin
      bit_time(int'(div));
      shift[i] = ser_txd;
    end
    bit_time(int'(div));
    rx_q.push_back(shift);
    // Busy to the end of the stop bit, so the host never talks over it
    bit_time(int'(div) - int'(div) / 2);
    rx_busy = 1'b0;
  end
endmodule : rcf_host_model

// ==== test_remote_command_framer.sv ====
// Self-checking bench of the remote command framer
`timescale 1ns/10ps
module test_remote_command_framer
  import rcf_pkg::*;
;
  logic sys_clk, rst, flow_en, ser_rxd, ser_txd, ser_cts_n, ser_rts_n;
  logic [1:0] rate_sel;
  rcf_byte_type usb_rx, usb_tx;
  logic usb_tx_ready, cmd_ferr, rep_valid, rep_last, rep_ready;
  rcf_cmd_type cmd_out;
  rcf_port_type port_sel;
  logic [7:0] rep_data;
  logic [DIV_W-1:0] div;
  logic [9:0] ev_q[$];
  logic [7:0] usb_q[$];
  int n_fail = 0;
  int checked = 0;

  assign div = (rate_sel == 2'h1) ? DIV_MID : (rate_sel == 2'h2) ? DIV_LO : DIV_HI;

  rcf_top i_dut (.sys_clk(sys_clk), .rst(rst), .rate_sel(rate_sel), .flow_en(flow_en), .ser_rxd(ser_rxd),
    .ser_txd(ser_txd), .ser_cts_n(ser_cts_n), .ser_rts_n(ser_rts_n), .usb_rx(usb_rx), .usb_tx(usb_tx),
    .usb_tx_ready(usb_tx_ready), .cmd_out(cmd_out), .cmd_ferr(cmd_ferr), .port_sel(port_sel),
    .rep_valid(rep_valid), .rep_data(rep_data), .rep_last(rep_last), .rep_ready(rep_ready));
  rcf_host_model i_host (.sys_clk(sys_clk), .div(div), .ser_rxd(ser_rxd), .ser_txd(ser_txd),
    .ser_rts_n(ser_rts_n));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Pre-edge values, so registered pulses are seen once
  always @(posedge sys_clk) begin
    if (cmd_out.start) ev_q.push_back({1'b0, 2'h1, cmd_out.chr});
    if (cmd_out.valid) ev_q.push_back({1'b0, 2'h2, cmd_out.chr});
    if (cmd_out.stop) ev_q.push_back({cmd_out.query, 2'h3, 7'h00});
    if (cmd_ferr) ev_q.push_back(10'h000);
    if (usb_tx.valid) usb_q.push_back(usb_tx.data);
  end

  task automatic check_val(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cycles

  task automatic ser_str(input string s);
    foreach (s[i]) i_host.send_byte(8'(s[i]), 1'b1);
  endtask : ser_str

  task automatic usb_str(input string s);
    foreach (s[i]) begin
      usb_rx = {1'b1, 8'(s[i])};
      cycles(1);
      usb_rx = '0;
      cycles(1);
    end
  endtask : usb_str

  // Marker '!' stands for a framing fault pulse
  task automatic expect_cmd(input string s, input logic q);
    byte c;
    logic [9:0] e;
    logic [9:0] g;
    foreach (s[i]) begin
      c = s[i];
      if (c == "#") e = {1'b0, 2'h1, CH_OPEN};
      else if (c == "*") e = {q, 2'h3, 7'h00};
      else if (c == "!") e = 10'h000;
      else e = {1'b0, 2'h2, c[6:0]};
      g = (ev_q.size() > 0) ? ev_q.pop_front() : 10'h3FF;
      check_val("command event", e, g);
    end
    check_val("spare events", 10'h000, 10'(ev_q.size()));
  endtask : expect_cmd

  task automatic reply(input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    rep_valid = 1'b1;
    rep_data = b;
    rep_last = 1'b1;
    for (int n = 0; n < 1000 && !ok; n++) begin
      @(negedge sys_clk);
      ok = rep_ready;
      cycles(1);
    end
    rep_valid = 1'b0;
    check_val("reply taken", 10'h001, {9'h0, ok});
  endtask : reply

  task automatic wait_q(input int n, input int lim);
    repeat (lim) begin
      if (i_host.rx_q.size() + usb_q.size() >= n) break;
      @(posedge sys_clk);
    end
    #1;
  endtask : wait_q

  task automatic pop_reply(input logic usb, input logic [8:0] e);
    logic [9:0] g;
    g = 10'h3FF;
    if (usb && usb_q.size() > 0) g = {2'h0, usb_q.pop_front()};
    if (!usb && i_host.rx_q.size() > 0) g = {1'b0, i_host.rx_q.pop_front()};
    check_val("reply byte", {1'b0, e}, g);
  endtask : pop_reply

  task automatic expect_reply(input logic usb, input logic rts, input logic [6:0] c);
    pop_reply(usb, {rts, 1'b0, c});
    pop_reply(usb, {rts, 1'b0, CH_CR});
    pop_reply(usb, {rts, 1'b0, CH_LF});
    check_val("extra bytes", 10'h000, 10'(i_host.rx_q.size() + usb_q.size()));
  endtask : expect_reply

  task automatic t_reset();
    cycles(2);
    check_val("idle line", 10'h001, {9'h0, ser_txd});
    check_val("ready", 10'h000, {9'h0, ser_rts_n});
    $display("reset state done");
  endtask : t_reset

  task automatic t_query_flow();
    flow_en = 1'b1;
    ser_cts_n = 1'b1;
    ser_str("#?V*");
    expect_cmd("#?V*", 1'b1);
    check_val("port", 10'h000, {9'h0, port_sel});
    fork
      reply(8'hD6);
    join_none
    cycles(400);
    check_val("held bytes", 10'h000, 10'(i_host.rx_q.size()));
    ser_cts_n = 1'b0;
    wait_q(3, 8000);
    expect_reply(1'b0, 1'b1, 7'h56);
    flow_en = 1'b0;
    $display("query with flow control done");
  endtask : t_query_flow

  task automatic t_restart();
    ser_str("Z#A#CD*");
    expect_cmd("#A#CD*", 1'b0);
    reply(8'h41);
    cycles(3000);
    check_val("unsolicited", 10'h000, 10'(i_host.rx_q.size() + usb_q.size()));
    $display("restart and setting done");
  endtask : t_restart

  task automatic t_ferr();
    ser_str("#A");
    i_host.send_byte(8'h42, 1'b0);
    cycles(300);
    ser_str("*");
    expect_cmd("#A!", 1'b0);
    $display("framing fault done");
  endtask : t_ferr

  task automatic t_usb();
    usb_str("#?U*");
    cycles(4);
    expect_cmd("#?U*", 1'b1);
    check_val("port", 10'h001, {9'h0, port_sel});
    usb_tx_ready = 1'b0;
    // Reply waits for USB readiness, so it runs alongside
    fork
      reply(8'hD5);
    join_none
    cycles(20);
    check_val("stalled bytes", 10'h000, 10'(usb_q.size()));
    usb_tx_ready = 1'b1;
    wait_q(3, 200);
    expect_reply(1'b1, 1'b0, 7'h55);
    $display("usb query done");
  endtask : t_usb

  task automatic t_rates();
    rate_sel = 2'h1;
    cycles(2);
    ser_str("#");
    i_host.send_byte(8'hC2, 1'b1);
    ser_str("*");
    expect_cmd("#B*", 1'b0);
    check_val("port", 10'h000, {9'h0, port_sel});
    rate_sel = 2'h2;
    cycles(2);
    ser_str("#");
    expect_cmd("#", 1'b0);
    rate_sel = 2'h3;
    cycles(2);
    ser_str("*");
    expect_cmd("*", 1'b0);
    $display("rates done");
  endtask : t_rates

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Tests need about 90000 clocks
  initial begin
    repeat (99000) @(posedge sys_clk);
    n_fail++;
    $display("MISMATCH watchdog expected finish seen timeout");
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    rate_sel = 2'h0;
    flow_en = 1'b0;
    ser_cts_n = 1'b0;
    usb_rx = '0;
    usb_tx_ready = 1'b1;
    rep_valid = 1'b0;
    rep_data = 8'h00;
    rep_last = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_query_flow();
    t_restart();
    t_ferr();
    t_usb();
    t_rates();
    print_verdict();
  end
endmodule : test_remote_command_framer
